/* inc/adc_seq_pkg.sv */
// Shared constants for the converter input mux and sequencer
package adc_seq_pkg;
	// Register word addresses on the plain register port
	localparam logic [3:0] ADDR_CTRL_ONE = 4'h0; // Module on, trigger, sampling bits
	localparam logic [3:0] ADDR_CTRL_TWO = 4'h1; // Channels, scan, rate, alternate
	localparam logic [3:0] ADDR_CTRL_THREE = 4'h2; // Auto-sample and conversion clock divide
	localparam logic [3:0] ADDR_MUX_SEL = 4'h3; // Input mux select
	localparam logic [3:0] ADDR_PIN_CFG = 4'h4; // Pin analog config
	localparam logic [3:0] ADDR_SCAN_MASK = 4'h5; // Scan input mask
	localparam logic [3:0] ADDR_STATUS = 4'h6; // Live sequencer state
	localparam logic [3:0] ADDR_BUF_BASE = 4'h8; // Result buffer window, 8 words
	// Reset values
	localparam logic [15:0] RST_REG = 16'h0000;
	// Control one field positions
	localparam int C1_ON = 15;
	localparam int C1_TRIG_LO = 5;
	localparam int C1_SIMULTANEOUS_SAMPLE = 3;
	localparam int C1_AUTO_SAMPLE = 2;
	localparam int C1_SAMPLE_ENABLE = 1;
	localparam int C1_DONE = 0;
	// Control two field positions
	localparam int C2_SCAN = 10;
	localparam int C2_CHANNELS_PER_SAMPLE_LO = 8;
	localparam int C2_RATE_LO = 2;
	localparam int C2_ALT = 0;
	// Control three field positions
	localparam int C3_SAMC_LO = 8;
	localparam int C3_DIV_LO = 0;
	// Mux select field positions within one byte
	localparam int MX_NEG13_LO = 6;
	localparam int MX_POS13 = 5;
	localparam int MX_NEG0 = 4;
	localparam int MX_POS0_LO = 0;
	localparam int MX_B_OFS = 8;
	// Trigger source codes
	localparam logic [2:0] TRIG_MANUAL = 3'h0;
	localparam logic [2:0] TRIG_EXT0 = 3'h1;
	localparam logic [2:0] TRIG_EXT1 = 3'h2;
	localparam logic [2:0] TRIG_EXT2 = 3'h3;
	localparam logic [2:0] TRIG_AUTO = 3'h7;
	// Timing: conversion length in conversion clock periods
	localparam int CONV_PERIODS = 12;
	localparam int BUF_DEPTH = 16;
	// Mux codes for channel inputs: 0..15 analog input, 16 negative reference, 17 ground
	localparam logic [4:0] SEL_VREF_NEG = 5'h10;
	localparam logic [4:0] SEL_GND = 5'h11;
endpackage

/* src/conv_clk_div.sv */
// Conversion clock divider producing a one-cycle tick per conversion clock period
`timescale 1ns/1ns
`default_nettype none
module conv_clk_div #(
	parameter int W = 6
) (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic run_i,
	input wire logic [W-1:0] div_i,
	output logic tick_o
);
	logic [W-1:0] cnt_q; // Cycles into current period

	initial begin
		if (W < 1) $error("divider width too small");
	end

	// Period is div_i+1 main clocks; held at zero when idle so timing restarts clean
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_q <= '0;
			tick_o <= 1'b0;
		end else if (!run_i) begin
			cnt_q <= '0;
			tick_o <= 1'b0;
		end else if (cnt_q >= div_i) begin
			cnt_q <= '0;
			tick_o <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 1'b1;
			tick_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* src/scan_pick.sv */
// Picks the lowest set bit of a mask at or above a start index
`timescale 1ns/1ns
`default_nettype none
module scan_pick #(
	parameter int N = 16
) (
	input wire logic [N-1:0] mask_i,
	input wire logic [$clog2(N)-1:0] from_i,
	output logic found_o,
	output logic [$clog2(N)-1:0] idx_o
);
	initial begin
		if (N < 2) $error("scan width too small");
	end

	// Search from the top down so the lowest hit wins
	always_comb begin
		found_o = 1'b0;
		idx_o = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (mask_i[i] && (i >= int'(from_i))) begin
				found_o = 1'b1;
				idx_o = i[$clog2(N)-1:0];
			end
		end
	end
endmodule
`default_nettype wire

/* src/adc_input_mux_sequencer.sv */
// Converter input mux selection, pin configuration and sample/convert sequencer
`timescale 1ns/1ns
`default_nettype none
module adc_input_mux_sequencer #(
	parameter int DIV_W = 6
) (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic [3:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	input wire logic [2:0] hw_trig_i, // Hardware trigger events, from pins
	input wire logic [9:0] result_i, // Converter result, same clock
	output logic [4:0] ch0_pos_o, // Channel 0 positive mux code
	output logic [4:0] ch0_neg_o,
	output logic [14:0] ch13_pos_o, // Channels 1..3 positive codes, 5 bits each
	output logic [14:0] ch13_neg_o,
	output logic [3:0] track_o, // Per channel: sample/hold connected to input
	output logic convert_o, // Converter running
	output logic [1:0] conv_ch_o, // Channel being converted
	output logic [15:0] pin_digital_mode_o, // One per pin: digital, port read enabled
	output logic irq_o // One-cycle interrupt pulse
);
	import adc_seq_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_SAMPLE = 4'b0010,
		ST_CONVERT = 4'b0100,
		ST_NEXT = 4'b1000
	} seq_state_t;

	logic [15:0] ctrl1_q, ctrl2_q, ctrl3_q; // Control registers
	logic [15:0] input_mux_select_q, pin_analog_config_q, scan_input_mask_q;
	logic [9:0] result_buffer_q [BUF_DEPTH]; // Result storage, flip-flops
	seq_state_t st_q;
	logic [3:0] tad_cnt_q; // Conversion clock periods elapsed
	logic [4:0] samc_cnt_q; // Auto-convert interval counter
	logic [1:0] ch_q; // Channel converted now
	logic [3:0] wr_idx_q; // Result write index
	logic [3:0] seq_cnt_q; // Sequences since last interrupt
	logic use_b_q; // Alternation phase, B when set
	logic [3:0] scan_pos_q; // Next scan search start
	logic [2:0] trig_s1_q, trig_s2_q, trig_s3_q; // Trigger synchroniser and edge history
	logic sample_enable_fall; // Software ended sampling
	logic tad_tick;
	logic trig_fire;
	logic scan_found;
	logic [3:0] scan_idx;
	logic [1:0] last_ch;
	logic [7:0] mux_byte;
	logic [4:0] ch0_pos_d;

	initial begin
		if (DIV_W != 6) $error("divider width must be 6");
	end

	// Field aliases
	wire on = ctrl1_q[C1_ON];
	wire [2:0] trig_sel = ctrl1_q[C1_TRIG_LO +: 3];
	wire simultaneous_sample = ctrl1_q[C1_SIMULTANEOUS_SAMPLE];
	wire auto_sample = ctrl1_q[C1_AUTO_SAMPLE];
	wire sample_enable = ctrl1_q[C1_SAMPLE_ENABLE];
	wire scan_en = ctrl2_q[C2_SCAN];
	wire [1:0] channels_per_sample = ctrl2_q[C2_CHANNELS_PER_SAMPLE_LO +: 2];
	wire [3:0] rate = ctrl2_q[C2_RATE_LO +: 4];
	wire alt = ctrl2_q[C2_ALT];
	wire [4:0] samc = ctrl3_q[C3_SAMC_LO +: 5];

	// Last channel of a sequence from channels-per-sample
	assign last_ch = channels_per_sample[1] ? 2'd3 : (channels_per_sample[0] ? 2'd1 : 2'd0);

	// Active mux byte: B upper, A lower
	assign mux_byte = use_b_q ? input_mux_select_q[MX_B_OFS +: 8] : input_mux_select_q[7:0];

	scan_pick #(.N(16)) u_scan (
		.mask_i(scan_input_mask_q),
		.from_i(scan_pos_q),
		.found_o(scan_found),
		.idx_o(scan_idx)
	);

	conv_clk_div #(.W(DIV_W)) u_div (
		.mclk_i(mclk_i),
		.arst_n_i(arst_n_i),
		.run_i(on && !(st_q == ST_SAMPLE && trig_fire)), // period restarts with the conversion
		.div_i(ctrl3_q[C3_DIV_LO +: DIV_W]),
		.tick_o(tad_tick)
	);

	// Hardware trigger pins: two-stage synchroniser plus edge history
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			trig_s1_q <= '0;
			trig_s2_q <= '0;
			trig_s3_q <= '0;
		end else begin
			trig_s1_q <= hw_trig_i;
			trig_s2_q <= trig_s1_q;
			trig_s3_q <= trig_s2_q;
		end
	end

	// Software clear of sample enable seen on the bus write
	assign sample_enable_fall = wr_i && addr_i == ADDR_CTRL_ONE && sample_enable && !wdata_i[C1_SAMPLE_ENABLE];

	// Trigger selection
	always_comb begin
		case (trig_sel)
			TRIG_MANUAL: trig_fire = sample_enable_fall;
			TRIG_EXT0: trig_fire = trig_s2_q[0] && !trig_s3_q[0];
			TRIG_EXT1: trig_fire = trig_s2_q[1] && !trig_s3_q[1];
			TRIG_EXT2: trig_fire = trig_s2_q[2] && !trig_s3_q[2];
			TRIG_AUTO: trig_fire = tad_tick && samc_cnt_q >= samc;
			default: trig_fire = 1'b0; // Reserved codes never trigger
		endcase
	end

	// Channel 0 positive selection: scan overrides setting A only
	always_comb begin
		if (scan_en && !use_b_q && scan_found) begin
			ch0_pos_d = {1'b0, scan_idx};
		end else begin
			ch0_pos_d = {1'b0, mux_byte[MX_POS0_LO +: 4]};
		end
	end

	// Mux outputs, with digital pins forced to ground
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ch0_pos_o <= SEL_VREF_NEG;
			ch0_neg_o <= SEL_VREF_NEG;
			ch13_pos_o <= {3{SEL_VREF_NEG}};
			ch13_neg_o <= {3{SEL_VREF_NEG}};
			pin_digital_mode_o <= '0;
		end else begin
			pin_digital_mode_o <= pin_analog_config_q;
			ch0_pos_o <= pin_analog_config_q[ch0_pos_d[3:0]] ? SEL_GND : ch0_pos_d;
			if (mux_byte[MX_NEG0]) begin
				ch0_neg_o <= pin_analog_config_q[1] ? SEL_GND : 5'h01;
			end else begin
				ch0_neg_o <= SEL_VREF_NEG;
			end
			for (int c = 0; c < 3; c++) begin
				logic [3:0] p;
				logic [3:0] n;
				p = mux_byte[MX_POS13] ? 4'(c + 3) : 4'(c);
				n = mux_byte[MX_NEG13_LO] ? 4'(c + 9) : 4'(c + 6);
				ch13_pos_o[c*5 +: 5] <= pin_analog_config_q[p] ? SEL_GND : {1'b0, p};
				if (mux_byte[MX_NEG13_LO + 1]) begin
					ch13_neg_o[c*5 +: 5] <= pin_analog_config_q[n] ? SEL_GND : {1'b0, n};
				end else begin
					ch13_neg_o[c*5 +: 5] <= SEL_VREF_NEG;
				end
			end
		end
	end

	// Sequencer: sample, then convert each channel for 12 periods
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_q <= ST_IDLE;
			tad_cnt_q <= '0;
			ch_q <= '0;
		end else if (!on) begin
			st_q <= ST_IDLE;
			tad_cnt_q <= '0;
			ch_q <= '0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (sample_enable || auto_sample) begin
						st_q <= ST_SAMPLE;
					end
				end
				ST_SAMPLE: begin
					if (trig_fire) begin
						st_q <= ST_CONVERT;
						tad_cnt_q <= '0;
						ch_q <= '0;
					end else if (!sample_enable && !auto_sample) begin
						st_q <= ST_IDLE;
					end
				end
				ST_CONVERT: begin
					if (tad_tick) begin
						if (tad_cnt_q == 4'(CONV_PERIODS - 1)) begin
							tad_cnt_q <= '0;
							if (ch_q == last_ch) begin
								st_q <= ST_NEXT;
							end else begin
								ch_q <= ch_q + 2'd1;
							end
						end else begin
							tad_cnt_q <= tad_cnt_q + 4'd1;
						end
					end
				end
				ST_NEXT: begin
					st_q <= auto_sample ? ST_SAMPLE : ST_IDLE;
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	wire conv_end = st_q == ST_CONVERT && tad_tick && tad_cnt_q == 4'(CONV_PERIODS - 1);
	wire seq_end = conv_end && ch_q == last_ch;
	wire irq_now = seq_end && seq_cnt_q == rate;

	// Track/hold and conversion outputs
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			track_o <= '0;
			convert_o <= 1'b0;
			conv_ch_o <= '0;
		end else begin
			convert_o <= st_q == ST_CONVERT;
			conv_ch_o <= ch_q;
			for (int c = 0; c < 4; c++) begin
				if (c > int'(last_ch)) begin
					track_o[c] <= 1'b0;
				end else if (st_q == ST_SAMPLE) begin
					track_o[c] <= 1'b1;
				end else if (st_q == ST_CONVERT && !simultaneous_sample) begin
					track_o[c] <= c > int'(ch_q); // later channels still sample
				end else begin
					track_o[c] <= 1'b0;
				end
			end
		end
	end

	// Auto-convert interval counter in conversion clock periods
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			samc_cnt_q <= '0;
		end else if (st_q != ST_SAMPLE) begin
			samc_cnt_q <= '0;
		end else if (tad_tick && samc_cnt_q != 5'h1f) begin
			samc_cnt_q <= samc_cnt_q + 5'd1;
		end
	end

	// Results, write index, interrupt rate, scan and alternation
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_idx_q <= '0;
			seq_cnt_q <= '0;
			use_b_q <= 1'b0;
			scan_pos_q <= '0;
			irq_o <= 1'b0;
			for (int i = 0; i < BUF_DEPTH; i++) begin
				result_buffer_q[i] <= '0;
			end
		end else begin
			irq_o <= irq_now;
			if (conv_end) begin
				result_buffer_q[wr_idx_q] <= result_i;
				wr_idx_q <= irq_now ? 4'd0 : wr_idx_q + 4'd1;
			end
			if (seq_end) begin
				seq_cnt_q <= irq_now ? 4'd0 : seq_cnt_q + 4'd1;
			end
			if (!alt) begin
				use_b_q <= 1'b0;
			end else if (seq_end) begin
				use_b_q <= !use_b_q;
			end
			if (irq_now) begin
				scan_pos_q <= '0;
			end else if (seq_end && scan_en && !use_b_q && scan_found) begin
				scan_pos_q <= scan_idx + 4'd1;
			end
		end
	end

	// Register writes; hardware set/clear of sample and done bits wins over software
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl1_q <= RST_REG;
			ctrl2_q <= RST_REG;
			ctrl3_q <= RST_REG;
			input_mux_select_q <= RST_REG;
			pin_analog_config_q <= RST_REG;
			scan_input_mask_q <= RST_REG;
		end else begin
			if (wr_i) begin
				case (addr_i)
					ADDR_CTRL_ONE: ctrl1_q <= wdata_i & 16'h80ef;
					ADDR_CTRL_TWO: ctrl2_q <= wdata_i & 16'h073d;
					ADDR_CTRL_THREE: ctrl3_q <= wdata_i & 16'h1f3f;
					ADDR_MUX_SEL: input_mux_select_q <= wdata_i;
					ADDR_PIN_CFG: pin_analog_config_q <= wdata_i;
					ADDR_SCAN_MASK: scan_input_mask_q <= wdata_i;
					default: ;
				endcase
			end
			if (st_q == ST_SAMPLE && trig_fire) begin
				ctrl1_q[C1_SAMPLE_ENABLE] <= 1'b0; // Sampling ended
				ctrl1_q[C1_DONE] <= 1'b0;
			end else if (st_q == ST_NEXT && auto_sample) begin
				ctrl1_q[C1_SAMPLE_ENABLE] <= 1'b1;
			end
			if (seq_end) begin
				ctrl1_q[C1_DONE] <= 1'b1;
			end
		end
	end

	// Read data, one cycle after the strobe; unmapped reads as zero
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_o <= '0;
		end else if (rd_i) begin
			case (addr_i)
				ADDR_CTRL_ONE: rdata_o <= ctrl1_q;
				ADDR_CTRL_TWO: rdata_o <= ctrl2_q;
				ADDR_CTRL_THREE: rdata_o <= ctrl3_q;
				ADDR_MUX_SEL: rdata_o <= input_mux_select_q;
				ADDR_PIN_CFG: rdata_o <= pin_analog_config_q;
				ADDR_SCAN_MASK: rdata_o <= scan_input_mask_q;
				ADDR_STATUS: rdata_o <= {st_q, seq_cnt_q, wr_idx_q, ch_q, use_b_q, convert_o};
				default: begin
					if (addr_i[3]) begin
						rdata_o <= {6'h00, result_buffer_q[{1'b0, addr_i[2:0]}]};
					end else begin
						rdata_o <= '0;
					end
				end
			endcase
		end else begin
			rdata_o <= '0;
		end
	end
endmodule
`default_nettype wire

/* test/adc_seq_monitor.sv */
// Port checker for the converter input mux sequencer
`timescale 1ns/1ns
`default_nettype none
module adc_seq_monitor import adc_seq_pkg::*; #(
	parameter int DIV_W = 6
) (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic [3:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [15:0] rdata_o,
	input wire logic [2:0] hw_trig_i,
	input wire logic [9:0] result_i,
	input wire logic [4:0] ch0_pos_o,
	input wire logic [4:0] ch0_neg_o,
	input wire logic [14:0] ch13_pos_o,
	input wire logic [14:0] ch13_neg_o,
	input wire logic [3:0] track_o,
	input wire logic convert_o,
	input wire logic [1:0] conv_ch_o,
	input wire logic [15:0] pin_digital_mode_o,
	input wire logic irq_o
);
	logic [15:0] mux_q, pin_q, scan_q; // Shadows of plain config words
	logic [1:0] channels_per_sample_q; // Channels field shadow
	logic [9:0] run_q; // Cycles convert has stood high
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);
	// Shadows follow bus writes, so readback is judged without the design
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mux_q <= '0;
			pin_q <= '0;
			scan_q <= '0;
			channels_per_sample_q <= '0;
		end else if (wr_i) begin
			if (addr_i == ADDR_MUX_SEL) mux_q <= wdata_i;
			if (addr_i == ADDR_PIN_CFG) pin_q <= wdata_i;
			if (addr_i == ADDR_SCAN_MASK) scan_q <= wdata_i;
			if (addr_i == ADDR_CTRL_TWO) channels_per_sample_q <= wdata_i[C2_CHANNELS_PER_SAMPLE_LO +: 2];
		end
	end
	// Length of the running conversion burst
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) run_q <= '0;
		else run_q <= convert_o ? run_q + 10'd1 : 10'd0;
	end
	a_rdata_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
		else $error("read data not zero outside read cycle");
	a_mux_read_back: assert property ($past(rd_i) && $past(addr_i) == ADDR_MUX_SEL |-> rdata_o == $past(mux_q))
		else $error("mux select readback wrong");
	a_scan_read_back: assert property ($past(rd_i) && $past(addr_i) == ADDR_SCAN_MASK |-> rdata_o == $past(scan_q))
		else $error("scan mask readback wrong");
	a_pin_mode_follow: assert property (pin_digital_mode_o == $past(pin_q))
		else $error("pin mode output does not follow config");
	a_irq_single_pulse: assert property (irq_o |=> !irq_o)
		else $error("interrupt longer than one cycle");
	a_conv_min_len: assert property ($fell(convert_o) |-> run_q >= CONV_PERIODS)
		else $error("conversion shorter than twelve periods");
	a_hold_during_conv: assert property (convert_o |-> !track_o[conv_ch_o])
		else $error("converted channel still tracking");
	a_conv_ch_range: assert property (convert_o |-> conv_ch_o <= (channels_per_sample_q[1] ? 2'd3 : {1'b0, channels_per_sample_q[0]}))
		else $error("converting unused channel");
	a_irq_seq_end: assert property (irq_o |-> convert_o ##1 !convert_o)
		else $error("interrupt not at sequence end");
	c_irq: cover property (irq_o);
	c_four_ch: cover property (convert_o && conv_ch_o == 2'd3);
	c_mux_read: cover property ($past(rd_i) && $past(addr_i) == ADDR_MUX_SEL);
endmodule
bind adc_input_mux_sequencer adc_seq_monitor #(.DIV_W(DIV_W)) mon_u (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .hw_trig_i(hw_trig_i),
	.result_i(result_i), .ch0_pos_o(ch0_pos_o), .ch0_neg_o(ch0_neg_o), .ch13_pos_o(ch13_pos_o),
	.ch13_neg_o(ch13_neg_o), .track_o(track_o), .convert_o(convert_o), .conv_ch_o(conv_ch_o),
	.pin_digital_mode_o(pin_digital_mode_o), .irq_o(irq_o));
`default_nettype wire

/* test/adc_input_mux_sequencer_tb_top.sv */
// Self-checking bench for the converter input mux sequencer
`timescale 1ns/1ns
`default_nettype none
module adc_input_mux_sequencer_tb_top;
	import adc_seq_pkg::*;
	logic mclk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [3:0] addr_i = '0;
	logic [15:0] wdata_i = '0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [2:0] hw_trig_i = '0;
	logic [9:0] result_i = '0;
	logic [15:0] rdata_o, pin_digital_mode_o;
	logic [4:0] ch0_pos_o, ch0_neg_o;
	logic [14:0] ch13_pos_o, ch13_neg_o;
	logic [3:0] track_o;
	logic convert_o, irq_o;
	logic [1:0] conv_ch_o;
	int miscompares = 0;
	int n_tests = 0;
	logic [9:0] res_q[$]; // Results fed, in conversion order
	logic [4:0] pos_q[$]; // Channel 0 code sampled before each sequence
	int n_cyc; // Convert-high cycles in a window
	logic [3:0] ch_seen; // Channels converted in a window
	logic got_irq;
	logic prev_conv = 1'b0;
	logic [1:0] prev_ch = '0;
	logic [9:0] nr;
	adc_input_mux_sequencer #(.DIV_W(6)) dut_u (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .hw_trig_i(hw_trig_i),
		.result_i(result_i), .ch0_pos_o(ch0_pos_o), .ch0_neg_o(ch0_neg_o), .ch13_pos_o(ch13_pos_o),
		.ch13_neg_o(ch13_neg_o), .track_o(track_o), .convert_o(convert_o), .conv_ch_o(conv_ch_o),
		.pin_digital_mode_o(pin_digital_mode_o), .irq_o(irq_o));
	// 125 MHz
	always #4 mclk_i = ~mclk_i;
	// Fresh converter result as each channel starts converting
	always @(posedge mclk_i) begin
		prev_conv <= convert_o;
		prev_ch <= conv_ch_o;
		if (convert_o && (!prev_conv || conv_ch_o != prev_ch)) begin
			nr = 10'($urandom);
			result_i <= nr;
			res_q.push_back(nr);
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask
	task automatic rc(input logic [3:0] a, input logic [15:0] exp);
		logic [15:0] d;
		rd(a, d);
		chk(d, exp);
	endtask
	task automatic do_reset();
		arst_n_i <= 1'b0;
		repeat (12) @(posedge mclk_i);
		arst_n_i <= 1'b1;
	endtask
	// Watch until the interrupt, bounded; gather conversion facts
	task automatic run_win();
		logic pc;
		logic [4:0] pp;
		pc = 1'b0;
		pp = ch0_pos_o;
		n_cyc = 0;
		ch_seen = '0;
		got_irq = 1'b0;
		pos_q.delete();
		for (int i = 0; i < 3000 && !got_irq; i++) begin
			@(posedge mclk_i);
			#1;
			if (convert_o && !pc) pos_q.push_back(pp);
			if (convert_o) n_cyc++;
			if (convert_o) ch_seen[conv_ch_o] = 1'b1;
			pc = convert_o;
			pp = ch0_pos_o;
			got_irq = irq_o;
		end
		chk(got_irq, 1'b1);
	endtask
	// Digital-mode pins feed ground to the mux
	function automatic logic [4:0] gnd(input logic [4:0] c, input logic [15:0] pc);
		return (c < 5'h10 && pc[c[3:0]]) ? SEL_GND : c;
	endfunction
	function automatic logic [4:0] nth(input logic [15:0] v, input int j);
		int n = 0;
		for (int b = 0; b < 16; b++) begin
			if (v[b] && n == j) return 5'(b);
			if (v[b]) n++;
		end
		return 5'h1f;
	endfunction
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Hang guard, far beyond the expected run
	initial begin
		#400000;
		miscompares++;
		summarize();
	end
	initial begin
		logic [15:0] d, m, p, sm;
		logic [3:0] used;
		int k, nch, dv;
		void'($urandom(32'h369e6a92));
		do_reset();
		// Reset values, unmapped word, readback
		for (int a = 0; a < 8; a++) if (a != 6) rc(4'(a), 16'h0000);
		for (int i = 0; i < 3; i++) begin
			d = 16'($urandom);
			if (i == 1) p = d;
			wr(ADDR_MUX_SEL + 4'(i), d);
			rc(ADDR_MUX_SEL + 4'(i), d);
		end
		chk(pin_digital_mode_o, p);
		wr(4'h7, 16'hffff);
		rc(4'h7, 16'h0000);
		// Manual sampling, software trigger, 1/2/4 channels
		for (int i = 0; i < 6; i++) begin
			m = 16'($urandom);
			p = 16'($urandom & $urandom & $urandom);
			nch = (i % 3 == 2) ? 4 : i % 3 + 1;
			used = 4'((1 << nch) - 1);
			dv = i % 4;
			sm = 16'((i % 2) << C1_SIMULTANEOUS_SAMPLE);
			wr(ADDR_PIN_CFG, p);
			wr(ADDR_MUX_SEL, m);
			wr(ADDR_CTRL_TWO, 16'((i % 3) << C2_CHANNELS_PER_SAMPLE_LO));
			wr(ADDR_CTRL_THREE, 16'(dv));
			wr(ADDR_CTRL_ONE, 16'h8002 | sm);
			repeat (4) @(posedge mclk_i);
			#1;
			chk(ch0_pos_o, gnd(5'(m[3:0]), p));
			chk(ch0_neg_o, gnd(m[4] ? 5'd1 : SEL_VREF_NEG, p));
			for (int c = 1; c < 4; c++) begin
				chk(ch13_pos_o[(c-1)*5 +: 5], gnd(5'(m[5] ? c + 2 : c - 1), p));
				chk(ch13_neg_o[(c-1)*5 +: 5], gnd(m[7] ? 5'(m[6] ? c + 8 : c + 5) : SEL_VREF_NEG, p));
			end
			chk(track_o, used);
			res_q.delete();
			wr(ADDR_CTRL_ONE, 16'h8000 | sm);
			run_win();
			chk(ch_seen, used);
			chk(n_cyc >= 12*(dv+1)*nch && n_cyc <= 15*(dv+1)*nch, 1'b1);
			rc(ADDR_CTRL_ONE, 16'h8001 | sm);
			for (int j = 0; j < nch; j++) begin
				rd(ADDR_BUF_BASE + 4'(j), d);
				chk(d[9:0], res_q[j]);
			end
		end
		// Hardware trigger pins, then a reserved code that must not fire
		do_reset();
		for (int t = 1; t < 5; t++) begin
			wr(ADDR_CTRL_ONE, 16'h8002 | 16'(t << C1_TRIG_LO));
			repeat (3) @(posedge mclk_i);
			hw_trig_i <= (t < 4) ? 3'(1 << (t - 1)) : 3'h7;
			repeat (3) @(posedge mclk_i);
			hw_trig_i <= 3'h0;
			if (t < 4) begin
				run_win();
			end else begin
				repeat (60) @(posedge mclk_i);
				#1 chk({convert_o, track_o[0]}, 2'b01);
			end
		end
		wr(ADDR_CTRL_ONE, 16'h0000);
		// Endless auto mode: scan pass, then A/B alternation
		for (int s = 0; s < 2; s++) begin
			do_reset();
			m = 16'($urandom);
			p = 16'($urandom) | 16'h0101;
			k = (s == 0 && $countones(p) < 4) ? $countones(p) : 4;
			wr(ADDR_MUX_SEL, m);
			wr(ADDR_SCAN_MASK, p);
			wr(ADDR_CTRL_THREE, 16'h0201);
			wr(ADDR_CTRL_TWO, 16'((s == 1 ? 1 : 16'h0400) | ((k - 1) << C2_RATE_LO)));
			wr(ADDR_CTRL_ONE, 16'h80e4);
			for (int w = 0; w < 2; w++) begin
				run_win();
				chk(16'(pos_q.size()), 16'(k));
				for (int j = 0; j < k; j++) begin
					chk(pos_q[j], (s == 1) ? {1'b0, (j % 2) ? m[11:8] : m[3:0]} : nth(p, j));
				end
			end
			wr(ADDR_CTRL_ONE, 16'h0000);
		end
		summarize();
	end
endmodule
`default_nettype wire
